//--- logic/vlan_port_tag_processor.v
// Design decisions made here: the APB register port and the register addresses.
`default_nettype none
`include "vlan_port_regs.vh"
module vlan_port_tag_processor (
    input  wire        ref_clk,
    input  wire        reset,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Ingress frame header
    input  wire        rxValid,
    input  wire [15:0] rxTpid,
    input  wire [11:0] rxVid,
    // Ingress classification result
    output wire        inValid,
    output wire [11:0] inVid,
    output wire        inDrop,
    output wire        inStrip,
    // Egress request from the forwarding engine
    input  wire        txReqValid,
    input  wire [11:0] txReqVid,
    // Egress decision
    output wire        txValid,
    output wire        txSend,
    output wire        txAddTag,
    output wire [15:0] txTpid,
    // Dynamic VLAN registration
    input  wire        regValid,
    input  wire [11:0] regVid,
    // Status
    output wire [11:0] egress_untagged_vlan_id,
    output wire        irq
);

    // ============================================================
    // Helpers

    // Tag protocol recognised by a port of the given type
    function tagRecognised;
        input [15:0] tpid;
        input [1:0]  ptype;
        begin
            case (ptype)
                `PTYPE_C: tagRecognised = (tpid == `TPID_CTAG);
                `PTYPE_S: tagRecognised = (tpid == `TPID_CTAG) ||
                                          (tpid == `TPID_STAG);
                default:  tagRecognised = 1'b0;
            endcase
        end
    endfunction

    function mappedAddr;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_PORT_CTRL,
                `OFS_DEFAULT_VID,
                `OFS_VLAN_CMD,
                `OFS_INT_STATUS,
                `OFS_INT_MASK,
                `OFS_CONFLICT_VID: mappedAddr = 1'b1;
                default:           mappedAddr = 1'b0;
            endcase
        end
    endfunction

    // ============================================================
    // Configuration registers

    reg  [31:0] ctrl_reg;
    reg  [11:0] port_default_vlan_id_reg;
    reg  [11:0] cfgVid_reg;
    reg  [11:0] conflictVid_reg;
    reg  [31:0] prdata_reg;

    wire        wrAcc   = psel & penable & pwrite;
    wire        rdSetup = psel & ~penable & ~pwrite;

    wire        wrCtrl   = wrAcc && (paddr == `OFS_PORT_CTRL);
    wire        wrDefVid = wrAcc && (paddr == `OFS_DEFAULT_VID);
    wire        wrCmd    = wrAcc && (paddr == `OFS_VLAN_CMD);
    wire        wrStatus = wrAcc && (paddr == `OFS_INT_STATUS);
    wire        wrMask   = wrAcc && (paddr == `OFS_INT_MASK);

    wire        hybrid    = ctrl_reg[`CTRL_HYBRID];
    wire [1:0]  cfgType   = ctrl_reg[`CTRL_TYPE_LSB+1:`CTRL_TYPE_LSB];
    wire [1:0]  cfgAccept = ctrl_reg[`CTRL_ACC_LSB+1:`CTRL_ACC_LSB];
    wire [1:0]  cfgEgress = ctrl_reg[`CTRL_EGR_LSB+1:`CTRL_EGR_LSB];
    wire        cfgFilter = ctrl_reg[`CTRL_FILTER];

    // Trunk ports are C-aware with filtering and accept all frames
    wire [1:0]  effType   = hybrid ? cfgType : `PTYPE_C;
    wire [1:0]  effAccept = hybrid ? cfgAccept : `ACC_ALL;
    wire        effFilter = hybrid ? cfgFilter : 1'b1;
    wire [1:0]  effEgress;
    // Type codes other than C and S behave as unaware
    wire        unaware   = (effType != `PTYPE_C) && (effType != `PTYPE_S);

    assign effEgress = !hybrid ? `EGR_UNTAG_DEFAULT :
                       unaware ? `EGR_UNTAG_ALL :
                       cfgEgress;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= `CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_reg <= {23'h00_0000, pwdata[8:0]};
        end
    end

    // A default VID of zero is rejected
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            port_default_vlan_id_reg <= `DEFAULT_VID_RESET;
        end else if (wrDefVid && (pwdata[11:0] != 12'h000)) begin
            port_default_vlan_id_reg <= pwdata[11:0];
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfgVid_reg <= 12'h000;
        end else if (wrCmd) begin
            cfgVid_reg <= pwdata[11:0];
        end
    end

    // ============================================================
    // Membership bitmaps

    wire        cmdAllowWr  = wrCmd && pwdata[`CMD_ALLOW_WR] &&
                              (pwdata[11:0] != 12'h000);
    wire        cmdForbidWr = wrCmd && pwdata[`CMD_FORBID_WR] &&
                              (pwdata[11:0] != 12'h000);
    wire        cmdClrAllow = wrCmd && pwdata[`CMD_CLEAR_ALLOW];
    wire        cmdSetAllow = wrCmd && pwdata[`CMD_SET_ALLOW];

    wire [11:0] classVid;
    wire        allowIn;
    wire        allowTx;
    wire        allowCfg;
    wire        forbidIn;
    wire        forbidTx;
    wire        forbidCfg;
    wire        forbidReg;
    wire        conflictCfg;

    wire        regLive     = regValid && (regVid != 12'h000);
    wire        regConflict = regLive && forbidReg;
    // Registration only joins a VLAN that is not forbidden
    wire        regJoin     = regLive && !forbidReg;
    // Clearing a forbidden bit also clears its conflict mark
    wire        conflictClr = cmdForbidWr && !pwdata[`CMD_FORBID_VAL];

    vlan_bitmap #(
        .RESET_ONES (1'b1)
    ) allowedSet (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clrAll  (cmdClrAllow),
        .setAll  (cmdSetAllow),
        .wrEn    (cmdAllowWr),
        .wrIdx   (pwdata[11:0]),
        .wrVal   (pwdata[`CMD_ALLOW_VAL]),
        .setEn   (regJoin),
        .setIdx  (regVid),
        .rdIdxA  (classVid),
        .rdIdxB  (txReqVid),
        .rdIdxC  (cfgVid_reg),
        .rdA     (allowIn),
        .rdB     (allowTx),
        .rdC     (allowCfg)
    );

    vlan_bitmap #(
        .RESET_ONES (1'b0)
    ) forbiddenSet (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clrAll  (1'b0),
        .setAll  (1'b0),
        .wrEn    (cmdForbidWr),
        .wrIdx   (pwdata[11:0]),
        .wrVal   (pwdata[`CMD_FORBID_VAL]),
        .setEn   (1'b0),
        .setIdx  (12'h000),
        .rdIdxA  (classVid),
        .rdIdxB  (txReqVid),
        .rdIdxC  (regVid),
        .rdA     (forbidIn),
        .rdB     (forbidTx),
        .rdC     (forbidReg)
    );

    // Conflict marks are only read back by software at the command VID
    vlan_bitmap #(
        .RESET_ONES (1'b0)
    ) conflictSet (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clrAll  (1'b0),
        .setAll  (1'b0),
        .wrEn    (conflictClr),
        .wrIdx   (pwdata[11:0]),
        .wrVal   (1'b0),
        .setEn   (regConflict),
        .setIdx  (regVid),
        .rdIdxA  (cfgVid_reg),
        .rdIdxB  (12'h000),
        .rdIdxC  (cfgVid_reg),
        .rdA     (conflictCfg),
        .rdB     (),
        .rdC     ()
    );

    vlan_bitmap #(
        .RESET_ONES (1'b0)
    ) forbiddenMirror (
        .ref_clk (ref_clk),
        .reset   (reset),
        .clrAll  (1'b0),
        .setAll  (1'b0),
        .wrEn    (cmdForbidWr),
        .wrIdx   (pwdata[11:0]),
        .wrVal   (pwdata[`CMD_FORBID_VAL]),
        .setEn   (1'b0),
        .setIdx  (12'h000),
        .rdIdxA  (cfgVid_reg),
        .rdIdxB  (12'h000),
        .rdIdxC  (12'h000),
        .rdA     (forbidCfg),
        .rdB     (),
        .rdC     ()
    );

    wire        memberIn  = allowIn & ~forbidIn;
    wire        memberTx  = allowTx & ~forbidTx;
    wire        memberCfg = allowCfg & ~forbidCfg;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            conflictVid_reg <= 12'h000;
        end else if (regConflict) begin
            conflictVid_reg <= regVid;
        end
    end

    // ============================================================
    // Ingress classification

    wire        tagKnown  = tagRecognised(rxTpid, effType);
    wire        tagAny    = tagRecognised(rxTpid, `PTYPE_S);
    // Unaware ports judge acceptance on any tag they carry
    wire        rxTagged  = unaware ? tagAny : tagKnown;

    // Priority-tagged frames fall back to the default VID
    assign classVid = (tagKnown && (rxVid != 12'h000)) ?
                      rxVid : port_default_vlan_id_reg;

    wire        dropTagged   = rxTagged &&
                               (effAccept == `ACC_UNTAGGED);
    wire        dropUntagged = !rxTagged &&
                               (effAccept == `ACC_TAGGED);
    wire        dropFilter   = effFilter && !memberIn;

    reg         inValid_reg;
    reg  [11:0] inVid_reg;
    reg         inDrop_reg;
    reg         inStrip_reg;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            inValid_reg <= 1'b0;
            inVid_reg   <= 12'h000;
            inDrop_reg  <= 1'b0;
            inStrip_reg <= 1'b0;
        end else begin
            inValid_reg <= rxValid;
            if (rxValid) begin
                inVid_reg   <= classVid;
                inDrop_reg  <= dropTagged | dropUntagged | dropFilter;
                inStrip_reg <= tagKnown;
            end
        end
    end

    // ============================================================
    // Egress tagging

    reg         txValid_reg;
    reg         txSend_reg;
    reg         txAddTag_reg;
    reg  [15:0] txTpid_reg;
    reg         addTag;

    always @* begin
        case (effEgress)
            `EGR_TAG_ALL:   addTag = 1'b1;
            `EGR_UNTAG_ALL: addTag = 1'b0;
            default:        addTag = (txReqVid != port_default_vlan_id_reg);
        endcase
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            txValid_reg  <= 1'b0;
            txSend_reg   <= 1'b0;
            txAddTag_reg <= 1'b0;
            txTpid_reg   <= `TPID_CTAG;
        end else begin
            txValid_reg <= txReqValid;
            if (txReqValid) begin
                txSend_reg   <= memberTx;
                txAddTag_reg <= memberTx & addTag;
                txTpid_reg   <= (effType == `PTYPE_S) ?
                                `TPID_STAG : `TPID_CTAG;
            end
        end
    end

    // ============================================================
    // Interrupts

    wire [`IRQ_WIDTH-1:0] events;
    wire [`IRQ_WIDTH-1:0] intStatus;
    wire [`IRQ_WIDTH-1:0] intMask;
    wire                  irqLine;

    assign events[`EV_TAGGED_DROP]   = rxValid & dropTagged;
    assign events[`EV_UNTAGGED_DROP] = rxValid & dropUntagged;
    assign events[`EV_FILTER_DROP]   = rxValid & dropFilter;
    assign events[`EV_CONFLICT]      = regConflict;

    event_irq irqUnit (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .events     (events),
        .wrStatus   (wrStatus),
        .wrMask     (wrMask),
        .wrData     (pwdata[`IRQ_WIDTH-1:0]),
        .status_reg (intStatus),
        .mask_reg   (intMask),
        .irq_reg    (irqLine)
    );

    // ============================================================
    // APB read path

    reg  [31:0] rd_next;

    always @* begin
        rd_next = 32'h0000_0000;
        case (paddr)
            `OFS_PORT_CTRL:    rd_next = ctrl_reg;
            `OFS_DEFAULT_VID:  rd_next = {20'h0_0000,
                                         port_default_vlan_id_reg};
            `OFS_VLAN_CMD:     rd_next = {12'h000, conflictCfg, memberCfg,
                                         forbidCfg, allowCfg, 4'h0,
                                         cfgVid_reg};
            `OFS_INT_STATUS:   rd_next = {28'h000_0000, intStatus};
            `OFS_INT_MASK:     rd_next = {28'h000_0000, intMask};
            `OFS_CONFLICT_VID: rd_next = {20'h0_0000, conflictVid_reg};
            default:           rd_next = 32'h0000_0000;
        endcase
    end

    // Read data is captured in the setup cycle and held through access
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rdSetup) begin
            prdata_reg <= rd_next;
        end
    end

    // ============================================================
    // Outputs

    assign prdata   = prdata_reg;
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mappedAddr(paddr);

    assign inValid  = inValid_reg;
    assign inVid    = inVid_reg;
    assign inDrop   = inDrop_reg;
    assign inStrip  = inStrip_reg;

    assign txValid  = txValid_reg;
    assign txSend   = txSend_reg;
    assign txAddTag = txAddTag_reg;
    assign txTpid   = txTpid_reg;

    assign egress_untagged_vlan_id = port_default_vlan_id_reg;
    assign irq      = irqLine;

endmodule
`default_nettype wire

//--- pkg/vlan_port_regs.vh
`ifndef VLAN_PORT_REGS_VH
`define VLAN_PORT_REGS_VH

// ============================================================
// Register offsets
`define OFS_PORT_CTRL     8'h00
`define OFS_DEFAULT_VID   8'h04
`define OFS_VLAN_CMD      8'h08
`define OFS_INT_STATUS    8'h0C
`define OFS_INT_MASK      8'h10
`define OFS_CONFLICT_VID  8'h14

// ============================================================
// Port control fields
`define CTRL_HYBRID       8
`define CTRL_EGR_LSB      6
`define CTRL_ACC_LSB      4
`define CTRL_FILTER       3
`define CTRL_TYPE_LSB     1
`define CTRL_RESET        32'h0000_0000

`define PTYPE_UNAWARE     2'h0
`define PTYPE_C           2'h1
`define PTYPE_S           2'h2
`define ACC_ALL           2'h0
`define ACC_TAGGED        2'h1
`define ACC_UNTAGGED      2'h2
`define EGR_UNTAG_DEFAULT 2'h0
`define EGR_TAG_ALL       2'h1
`define EGR_UNTAG_ALL     2'h2

// ============================================================
// VLAN command fields
`define CMD_ALLOW_VAL     16
`define CMD_FORBID_VAL    17
`define CMD_ALLOW_WR      18
`define CMD_FORBID_WR     19
`define CMD_CLEAR_ALLOW   20
`define CMD_SET_ALLOW     21
`define CMD_RD_MEMBER     18
`define CMD_RD_CONFLICT   19

// ============================================================
// Values
`define DEFAULT_VID_RESET 12'h001
`define TPID_CTAG         16'h8100
`define TPID_STAG         16'h88A8
`define IRQ_WIDTH         4
`define EV_TAGGED_DROP    0
`define EV_UNTAGGED_DROP  1
`define EV_FILTER_DROP    2
`define EV_CONFLICT       3

`endif

//--- logic/vlan_bitmap.v
`default_nettype none
module vlan_bitmap #(
    parameter RESET_ONES = 1'b0
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        clrAll,
    input  wire        setAll,
    input  wire        wrEn,
    input  wire [11:0] wrIdx,
    input  wire        wrVal,
    input  wire        setEn,
    input  wire [11:0] setIdx,
    input  wire [11:0] rdIdxA,
    input  wire [11:0] rdIdxB,
    input  wire [11:0] rdIdxC,
    output wire        rdA,
    output wire        rdB,
    output wire        rdC
);
    // VID 0 is never a member
    localparam [4095:0] ALL_BITS   = {{4095{1'b1}}, 1'b0};
    localparam [4095:0] RESET_BITS = RESET_ONES ? ALL_BITS : 4096'd0;

    reg [4095:0] bits_reg;

    // Dynamic set is applied last so it wins over a same-cycle clear
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bits_reg <= RESET_BITS;
        end else begin
            if (clrAll) begin
                bits_reg <= 4096'd0;
            end else if (setAll) begin
                bits_reg <= ALL_BITS;
            end else if (wrEn) begin
                bits_reg[wrIdx] <= wrVal;
            end
            if (setEn) begin
                bits_reg[setIdx] <= 1'b1;
            end
        end
    end

    assign rdA = bits_reg[rdIdxA];
    assign rdB = bits_reg[rdIdxB];
    assign rdC = bits_reg[rdIdxC];
endmodule
`default_nettype wire

//--- logic/event_irq.v
`default_nettype none
`include "vlan_port_regs.vh"
module event_irq (
    input  wire                  ref_clk,
    input  wire                  reset,
    input  wire [`IRQ_WIDTH-1:0] events,
    input  wire                  wrStatus,
    input  wire                  wrMask,
    input  wire [`IRQ_WIDTH-1:0] wrData,
    output reg  [`IRQ_WIDTH-1:0] status_reg,
    output reg  [`IRQ_WIDTH-1:0] mask_reg,
    output reg                   irq_reg
);
    wire [`IRQ_WIDTH-1:0] clrBits     = wrStatus ? wrData : {`IRQ_WIDTH{1'b0}};
    // New events win over a write-one-to-clear in the same cycle
    wire [`IRQ_WIDTH-1:0] status_next = (status_reg & ~clrBits) | events;
    wire [`IRQ_WIDTH-1:0] mask_next   = wrMask ? wrData : mask_reg;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            status_reg <= {`IRQ_WIDTH{1'b0}};
            mask_reg   <= {`IRQ_WIDTH{1'b0}};
            irq_reg    <= 1'b0;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            irq_reg    <= |(status_next & mask_next);
        end
    end
endmodule
`default_nettype wire

//--- tb/vlan_port_tag_processor_monitor.sv
`default_nettype none
module vlan_port_tag_processor_monitor (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic        rxValid,
    input wire logic [15:0] rxTpid,
    input wire logic [11:0] rxVid,
    input wire logic        inValid,
    input wire logic [11:0] inVid,
    input wire logic        inDrop,
    input wire logic        inStrip,
    input wire logic        txReqValid,
    input wire logic        txValid,
    input wire logic        txSend,
    input wire logic        txAddTag,
    input wire logic [15:0] txTpid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    // ==========================================================
    // Ingress
    in_answer_a: assert property (rxValid |=> inValid)
        else $error("ingress result missing");
    in_hold_a: assert property (
        !inValid |-> $stable(inVid) && $stable(inDrop))
        else $error("ingress result changed without a frame");
    strip_tpid_a: assert property (
        inValid && inStrip |->
        $past(rxTpid) == 16'h8100 || $past(rxTpid) == 16'h88A8)
        else $error("tag stripped for an unknown protocol");
    strip_vid_a: assert property (
        inValid && inStrip && $past(rxVid) != 12'h000
        |-> inVid == $past(rxVid))
        else $error("tagged frame not classified to its tag");
    vid_range_a: assert property (inValid |-> inVid != 12'h000)
        else $error("classified to VLAN zero");

    // ==========================================================
    // Egress
    tx_answer_a: assert property (txReqValid |=> txValid)
        else $error("egress decision missing");
    tag_only_sent_a: assert property (txValid && !txSend |-> !txAddTag)
        else $error("tag added to a frame not sent");
    tx_tpid_a: assert property (
        txValid |-> txTpid == 16'h8100 || txTpid == 16'h88A8)
        else $error("egress tag protocol invalid");

    cover property (inValid && inDrop);
    cover property (inValid && inStrip);
    cover property (txValid && txAddTag);
endmodule
`default_nettype wire

//--- tb/vlan_link_partner.sv
`default_nettype none
module vlan_link_partner (
    input  wire logic        ref_clk,
    output var  logic        rxValid,
    output var  logic [15:0] rxTpid,
    output var  logic [11:0] rxVid,
    output var  logic        txReqValid,
    output var  logic [11:0] txReqVid,
    output var  logic        regValid,
    output var  logic [11:0] regVid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {rxValid, txReqValid, regValid} = 3'h0;
        {rxTpid, rxVid, txReqVid, regVid} = '0;
    end
    // Released lines show the inverse of the last value
    task frame(input logic [15:0] t, input logic [11:0] v);
        rxValid <= 1'b1;
        rxTpid  <= t;
        rxVid   <= v;
        @(posedge ref_clk);
        rxValid <= 1'b0;
        rxTpid  <= ~t;
        rxVid   <= ~v;
    endtask
    task egress(input logic [11:0] v);
        txReqValid <= 1'b1;
        txReqVid   <= v;
        @(posedge ref_clk);
        txReqValid <= 1'b0;
        txReqVid   <= ~v;
    endtask
    task register(input logic [11:0] v);
        regValid <= 1'b1;
        regVid   <= v;
        @(posedge ref_clk);
        regValid <= 1'b0;
        regVid   <= ~v;
        @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

//--- tb/vlan_port_tag_processor_test.sv
`default_nettype none
`include "vlan_port_regs.vh"
module vlan_port_tag_processor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic        rxValid, inValid, inDrop, inStrip, txReqValid, txValid;
    logic        txSend, txAddTag, regValid, irq, err;
    logic [15:0] rxTpid, txTpid;
    logic [11:0] rxVid, inVid, txReqVid, regVid, egress_untagged_vlan_id;
    logic [11:0] v, dv;
    logic [8:0]  ctl;
    logic [3:0]  st;
    bit [4095:0] alw, fbd, cnf;
    int          n_errors, comparisons;
    integer      seed = 32'h0000_c9c7;

    vlan_port_tag_processor uut (.ref_clk, .reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .rxValid, .rxTpid,
        .rxVid, .inValid, .inVid, .inDrop, .inStrip, .txReqValid, .txReqVid,
        .txValid, .txSend, .txAddTag, .txTpid, .regValid, .regVid,
        .egress_untagged_vlan_id, .irq);
    vlan_link_partner lp (.ref_clk, .rxValid, .rxTpid, .rxVid, .txReqValid,
        .txReqVid, .regValid, .regVid);

    // ==========================================================
    // Helpers
    function automatic logic mem(input logic [11:0] x);
        return alw[x] & ~fbd[x];
    endfunction
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task finish_test;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task cmd(input logic [11:0] x, input logic [5:0] b);
        apb(1'b1, `OFS_VLAN_CMD, {10'h0, b, 4'h0, x});
        if (b[4]) alw = '0;
        else if (b[5]) alw = {{4095{1'b1}}, 1'b0};
        else if (b[2]) alw[x] = b[0];
        if (b[3]) begin
            fbd[x] = b[1];
            if (!b[1]) cnf[x] = 1'b0;
        end
        apb(1'b0, `OFS_VLAN_CMD, 32'h0000_0000);
        chk(rd, {12'h0, cnf[x], mem(x), fbd[x], alw[x], 4'h0, x});
    endtask
    task rx(input logic [15:0] t, input logic [11:0] x);
        logic [1:0]  ty, ac;
        logic        rc, tg;
        logic [11:0] ev;
        logic [2:0]  dr;
        ty = ctl[8] ? ctl[2:1] : 2'h1;
        ac = ctl[8] ? ctl[5:4] : 2'h0;
        rc = (t == 16'h8100 && ^ty) || (t == 16'h88A8 && ty == 2'h2);
        tg = ^ty ? rc : (t == 16'h8100 || t == 16'h88A8);
        ev = (rc && x != 0) ? x : dv;
        dr = {(!ctl[8] || ctl[3]) && !mem(ev), ac == 2'h1 && !tg,
              ac == 2'h2 && tg};
        st = st | {1'b0, dr};
        lp.frame(t, x);
        @(negedge ref_clk);
        chk(inValid, 1'b1);
        chk(inVid, ev);
        chk(inStrip, rc);
        chk(inDrop, |dr);
        chk(egress_untagged_vlan_id, dv);
        @(posedge ref_clk);
    endtask
    task tx(input logic [11:0] x);
        logic [1:0] ty, eg;
        ty = ctl[8] ? ctl[2:1] : 2'h1;
        eg = ctl[8] ? ctl[7:6] : 2'h0;
        lp.egress(x);
        @(negedge ref_clk);
        chk(txValid, 1'b1);
        chk(txSend, mem(x));
        chk(txAddTag, mem(x) && ^ty &&
            (eg == 2'h1 || (eg != 2'h2 && x != dv)));
        chk(txTpid, ty == 2'h2 ? 16'h88A8 : 16'h8100);
        @(posedge ref_clk);
    endtask
    task irq_is(input logic e);
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(irq, e);
        @(posedge ref_clk);
    endtask

    // ==========================================================
    // Clock, watchdog and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        finish_test();
    end
    initial begin
        {psel, penable, pwrite, reset} = 4'h1;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        alw = {{4095{1'b1}}, 1'b0};
        {fbd, cnf} = '0;
        st = 4'h0;
        ctl = 9'h000;
        dv = 12'h001;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, `OFS_DEFAULT_VID, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, `OFS_PORT_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        cmd(12'hFFF, 6'h00);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk({rd[30:0], err}, 32'h0000_0001);
        for (int i = 0; i < 400; i++) begin
            rnd = $random(seed);
            v = 12'(rnd[5:3]) + 12'h001;
            case (rnd[2:0])
                3'h0: begin
                    apb(1'b1, `OFS_PORT_CTRL, {23'h0, rnd[31:23]});
                    ctl = rnd[31:23];
                end
                3'h1: begin
                    apb(1'b1, `OFS_DEFAULT_VID, rnd[6] ? 32'h0 : 32'(v));
                    if (!rnd[6]) dv = v;
                    cmd(dv, 6'h05);
                end
                3'h2: cmd(v, {rnd[25:24] & {2{rnd[23:21] == 0}}, rnd[19:16]});
                3'h3: begin
                    lp.register(v);
                    if (fbd[v]) {cnf[v], st[3]} = 2'h3;
                    else alw[v] = 1'b1;
                end
                default: begin
                    rx(rnd[7] ? 16'h0800 : (rnd[8] ? 16'h88A8 : 16'h8100),
                       12'(rnd[12:9]) % 12'h009);
                    tx(v);
                end
            endcase
        end
        apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
        chk(rd, {28'h000_0000, st});
        apb(1'b1, `OFS_INT_MASK, 32'h0000_0000);
        apb(1'b1, `OFS_INT_STATUS, 32'h0000_000F);
        cmd(12'h009, 6'h0A);
        lp.register(12'h009);
        cnf[9] = 1'b1;
        apb(1'b0, `OFS_INT_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        irq_is(1'b0);
        apb(1'b1, `OFS_INT_MASK, 32'h0000_0008);
        irq_is(1'b1);
        apb(1'b0, `OFS_CONFLICT_VID, 32'h0000_0000);
        chk(rd, 32'h0000_0009);
        cmd(12'h009, 6'h00);
        apb(1'b1, `OFS_INT_STATUS, 32'h0000_0008);
        irq_is(1'b0);
        finish_test();
    end
endmodule

bind vlan_port_tag_processor vlan_port_tag_processor_monitor mon (
    .ref_clk, .reset, .rxValid, .rxTpid, .rxVid, .inValid, .inVid, .inDrop,
    .inStrip, .txReqValid, .txValid, .txSend, .txAddTag, .txTpid);
`default_nettype wire
